// >>> hdl/err_report_pkg.sv
// constants for the error code reporter
// assumes a 100 MHz pclk and an APB master
package err_report_pkg;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_TRIG_MODE = 8'h04;
  localparam logic [7:0] ADDR_VLIMIT    = 8'h08;
  localparam logic [7:0] ADDR_ILIMIT    = 8'h0c;
  localparam logic [7:0] ADDR_LAST_ERR  = 8'h10;
  localparam logic [7:0] ADDR_HISTORY   = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam int CTRL_MANUAL  = 0;
  localparam int CTRL_REMOTE  = 1;
  localparam int CTRL_IEEE    = 2;
  localparam int CTRL_LOCKOUT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam logic [2:0] TM_OFF = 3'h0;
  localparam logic [2:0] TM_OUT = 3'h1;
  localparam logic [2:0] TM_SEQ = 3'h2;
  localparam logic [2:0] TM_MIN = 3'h3;
  localparam logic [2:0] TM_AIU = 3'h4;
  localparam logic [2:0] TM_AII = 3'h5;
  localparam int TM_W = 3;
  localparam logic [31:0] VLIMIT_RESET = 32'hffff_0000;
  localparam logic [31:0] ILIMIT_RESET = 32'hffff_0000;
  localparam logic [7:0] E_NONE = 8'h00;
  localparam logic [7:0] E_KEY = 8'h05;
  localparam logic [7:0] E_CMDBUF = 8'h12;
  localparam logic [7:0] E_SETPT = 8'h21;
  localparam logic [7:0] E_LIMIT = 8'h22;
  localparam logic [7:0] E_MACRO = 8'h29;
  localparam logic [7:0] E_PARITY = 8'h51;
  localparam logic [7:0] E_STOP = 8'h52;
  localparam logic [7:0] E_BOTH = 8'h53;
  localparam logic [7:0] E_FRAME = 8'h54;
  localparam logic [7:0] E_NOLSN = 8'h55;
  localparam logic [7:0] E_TALKLSN = 8'h56;
  localparam logic [7:0] E_CALPAR = 8'h61;
  localparam logic [7:0] E_CALREM = 8'h62;
  localparam logic [7:0] E_CALMODE = 8'h63;
  localparam logic [7:0] E_CALMEAS = 8'h64;
  localparam logic [7:0] E_CALFAIL = 8'h66;
  localparam logic [7:0] E_MEM = 8'h69;
  localparam logic [7:0] E_SEQLIM = 8'h71;
  localparam logic [7:0] E_OUTTRG = 8'h73;
  localparam logic [7:0] E_MINTRG = 8'h74;
  localparam logic [7:0] E_SEQTRG = 8'h75;
  localparam logic [7:0] E_AITRG = 8'h76;
  localparam logic [23:0] MARKER_TEXT = 24'h457272;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam int MACRO_MAX = 80;
  localparam int CMD_DEPTH = 64;
  localparam logic [3:0] BITS_MIN = 4'h7;
  localparam logic [3:0] BITS_MAX = 4'h8;
  localparam longint CLK_FREQ_HZ = 100_000_000;
  localparam longint DISPLAY_TIME_MS = 2000;
  localparam int DISPLAY_CYCLES =
    int'((DISPLAY_TIME_MS * CLK_FREQ_HZ) / 1000);
endpackage

// >>> hdl/error_code_reporter.sv
// error detection, display and three-entry history of the supply
// assumes fault pulses on pclk, trigger levels from pins, APB access
`timescale 1ns/1ps
module error_code_reporter
#(
  parameter int DISPLAY_CYCLES = err_report_pkg::DISPLAY_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        key_unknown,
  input  wire logic        esc_brief,
  input  wire logic        cmd_char_in,
  input  wire logic        cmd_char_take,
  input  wire logic        setpoint_invalid,
  input  wire logic        limit_invalid,
  input  wire logic        macro_char,
  input  wire logic        macro_trig_query,
  input  wire logic        macro_end,
  input  wire logic        rx_char_done,
  input  wire logic        parity_fault,
  input  wire logic        stop_bit_fault,
  input  wire logic        serial_cfg_apply,
  input  wire logic [3:0]  data_bit_count,
  input  wire logic        parity_enable,
  input  wire logic        two_stop_bits,
  input  wire logic        addressed_talk,
  input  wire logic        listener_present,
  input  wire logic        talker_active,
  input  wire logic        listener_active,
  input  wire logic        cal_param_invalid,
  input  wire logic        calibration_command,
  input  wire logic        cal_step,
  input  wire logic        cal_step_current,
  input  wire logic        constant_voltage_regulation,
  input  wire logic        constant_current_regulation,
  input  wire logic        cal_limit_set,
  input  wire logic        cal_meas_bad,
  input  wire logic        cal_fail,
  input  wire logic        cal_success,
  input  wire logic        mem_check_fail,
  input  wire logic        seq_running,
  input  wire logic        seq_step,
  input  wire logic [15:0] table_voltage,
  input  wire logic [15:0] table_current,
  input  wire logic [1:0]  trigger_input_level,
  input  wire logic        output_on_req,
  input  wire logic        capture_on_req,
  input  wire logic        seq_start_req,
  input  wire logic        analog_change_req,
  output logic             request_rejected,
  output logic             uncalibrated_state,
  output logic             display_active,
  output logic      [23:0] display_left,
  output logic      [11:0] display_right,
  output logic      [7:0]  last_error
);

  typedef enum logic {DISP_IDLE, DISP_SHOW} disp_state_t;

  // true when trigger i is in mode m and its level blocks
  function automatic logic trig_blocks(
    input logic [5:0] modes,
    input logic [1:0] lvl,
    input logic [2:0] m
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      if (modes[i*3 +: 3] == m && lvl[i])
        hit = 1'b1;
    end
    return hit;
  endfunction

  // serial frame setup that cannot be sent
  function automatic logic frame_bad(
    input logic [3:0] nb,
    input logic       par,
    input logic       sb2
  );
    return (nb < err_report_pkg::BITS_MIN) ||
           (nb > err_report_pkg::BITS_MAX) ||
           (nb == err_report_pkg::BITS_MAX && par && sb2);
  endfunction

  logic [3:0]  ctrl_q;
  logic [5:0]  trig_mode_q;
  logic [31:0] vlimit_q;
  logic [31:0] ilimit_q;
  logic [1:0]  trig_meta_q;
  logic [1:0]  trig_sync_q;
  logic [6:0]  cmd_fill_q;
  logic [6:0]  macro_cnt_q;
  logic        macro_long_q;
  logic        macro_query_q;
  logic [23:0] hist_q;
  logic [7:0]  last_q;
  logic [7:0]  code_d;
  logic        reject_d;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        reject_q;
  logic        nocal_q;
  disp_state_t disp_q;
  logic [31:0] disp_cnt_q;
  logic [23:0] left_q;
  logic [11:0] right_q;
  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;
  logic        hist_clr;
  logic        out_blk;
  logic        min_blk;
  logic        seq_blk;
  logic        ai_blk;
  logic        mode_bad;
  logic        v_bad;
  logic        i_bad;

  // apb decode: setup sampled, write at the pready edge
  assign wr_acc   = psel && penable && pready_q && pwrite;
  assign rd_setup = psel && penable && !pready_q;
  assign mapped   = (paddr == err_report_pkg::ADDR_CTRL) ||
                    (paddr == err_report_pkg::ADDR_TRIG_MODE) ||
                    (paddr == err_report_pkg::ADDR_VLIMIT) ||
                    (paddr == err_report_pkg::ADDR_ILIMIT) ||
                    (paddr == err_report_pkg::ADDR_LAST_ERR) ||
                    (paddr == err_report_pkg::ADDR_HISTORY) ||
                    (paddr == err_report_pkg::ADDR_STATUS);
  assign hist_clr = wr_acc && paddr == err_report_pkg::ADDR_HISTORY;

  // trigger conflict decode on synchronised levels
  assign out_blk = trig_blocks(trig_mode_q, trig_sync_q,
                               err_report_pkg::TM_OUT);
  assign min_blk = trig_blocks(trig_mode_q, trig_sync_q,
                               err_report_pkg::TM_MIN);
  assign seq_blk = trig_blocks(trig_mode_q, trig_sync_q,
                               err_report_pkg::TM_SEQ);
  assign ai_blk  = trig_blocks(trig_mode_q, trig_sync_q,
                               err_report_pkg::TM_AIU) ||
                   trig_blocks(trig_mode_q, trig_sync_q,
                               err_report_pkg::TM_AII);

  // calibration mode check and sequence limit check
  assign mode_bad = cal_step_current ? !constant_current_regulation
                                     : !constant_voltage_regulation;
  assign v_bad = table_voltage < vlimit_q[15:0] ||
                 table_voltage > vlimit_q[31:16];
  assign i_bad = table_current < ilimit_q[15:0] ||
                 table_current > ilimit_q[31:16];

  // fault classification, lowest code wins a tie except that 53 beats 51 and 52
  always_comb
  begin
    code_d   = err_report_pkg::E_NONE;
    reject_d = 1'b0;
    if (key_unknown || (esc_brief && ctrl_q[err_report_pkg::CTRL_LOCKOUT]))
      code_d = err_report_pkg::E_KEY;
    else if (cmd_char_in && !cmd_char_take &&
             cmd_fill_q == 7'(err_report_pkg::CMD_DEPTH))
      code_d = err_report_pkg::E_CMDBUF;
    else if (setpoint_invalid)
      code_d = err_report_pkg::E_SETPT;
    else if (limit_invalid)
      code_d = err_report_pkg::E_LIMIT;
    else if (macro_end && (macro_long_q || macro_query_q ||
             macro_trig_query))
      code_d = err_report_pkg::E_MACRO;
    else if (rx_char_done && parity_fault && stop_bit_fault)
      code_d = err_report_pkg::E_BOTH;
    else if (rx_char_done && parity_fault)
      code_d = err_report_pkg::E_PARITY;
    else if (rx_char_done && stop_bit_fault)
      code_d = err_report_pkg::E_STOP;
    else if (serial_cfg_apply && ctrl_q[err_report_pkg::CTRL_MANUAL] &&
             frame_bad(data_bit_count, parity_enable, two_stop_bits))
      code_d = err_report_pkg::E_FRAME;
    else if (ctrl_q[err_report_pkg::CTRL_IEEE] && addressed_talk &&
             !listener_present)
      code_d = err_report_pkg::E_NOLSN;
    else if (ctrl_q[err_report_pkg::CTRL_IEEE] && talker_active &&
             listener_active)
      code_d = err_report_pkg::E_TALKLSN;
    else if (cal_param_invalid)
      code_d = err_report_pkg::E_CALPAR;
    else if (calibration_command && ctrl_q[err_report_pkg::CTRL_REMOTE])
      code_d = err_report_pkg::E_CALREM;
    else if (cal_step && mode_bad)
      code_d = err_report_pkg::E_CALMODE;
    else if (cal_limit_set && cal_meas_bad)
      code_d = err_report_pkg::E_CALMEAS;
    else if (cal_fail)
      code_d = err_report_pkg::E_CALFAIL;
    else if (mem_check_fail)
      code_d = err_report_pkg::E_MEM;
    else if (seq_running && seq_step && (v_bad || i_bad))
      code_d = err_report_pkg::E_SEQLIM;
    else if (output_on_req && out_blk)
    begin
      code_d   = err_report_pkg::E_OUTTRG;
      reject_d = 1'b1;
    end
    else if (capture_on_req && min_blk)
    begin
      code_d   = err_report_pkg::E_MINTRG;
      reject_d = 1'b1;
    end
    else if (seq_start_req && seq_blk)
    begin
      code_d   = err_report_pkg::E_SEQTRG;
      reject_d = 1'b1;
    end
    else if (analog_change_req && ai_blk)
    begin
      code_d   = err_report_pkg::E_AITRG;
      reject_d = 1'b1;
    end
  end

  // two-flop synchroniser for trigger pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_meta_q <= '0;
      trig_sync_q <= '0;
    end
    else
    begin
      trig_meta_q <= trigger_input_level;
      trig_sync_q <= trig_meta_q;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q      <= err_report_pkg::CTRL_RESET;
      trig_mode_q <= '0;
      vlimit_q    <= err_report_pkg::VLIMIT_RESET;
      ilimit_q    <= err_report_pkg::ILIMIT_RESET;
    end
    else if (wr_acc)
    begin
      case (paddr)
        err_report_pkg::ADDR_CTRL:      ctrl_q <= pwdata[3:0];
        err_report_pkg::ADDR_TRIG_MODE: trig_mode_q <= pwdata[5:0];
        err_report_pkg::ADDR_VLIMIT:    vlimit_q <= pwdata;
        err_report_pkg::ADDR_ILIMIT:    ilimit_q <= pwdata;
        default: ;
      endcase
    end
  end

  // apb answer: one wait state, read data taken at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= rd_setup;
      pslverr_q <= rd_setup && !mapped;
      if (rd_setup)
      begin
        case (paddr)
          err_report_pkg::ADDR_CTRL:      prdata_q <= {28'h0, ctrl_q};
          err_report_pkg::ADDR_TRIG_MODE: prdata_q <= {26'h0, trig_mode_q};
          err_report_pkg::ADDR_VLIMIT:    prdata_q <= vlimit_q;
          err_report_pkg::ADDR_ILIMIT:    prdata_q <= ilimit_q;
          err_report_pkg::ADDR_LAST_ERR:  prdata_q <= {24'h0, last_q};
          err_report_pkg::ADDR_HISTORY:   prdata_q <= {8'h0, hist_q};
          err_report_pkg::ADDR_STATUS:
            prdata_q <= {16'h0, cmd_fill_q, 7'h0,
                         disp_q == DISP_SHOW, nocal_q};
          default:                        prdata_q <= '0;
        endcase
      end
    end
  end

  // command buffer fill level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_fill_q <= '0;
    else if (cmd_char_in && !cmd_char_take &&
             cmd_fill_q != 7'(err_report_pkg::CMD_DEPTH))
      cmd_fill_q <= cmd_fill_q + 7'h01;
    else if (cmd_char_take && !cmd_char_in && cmd_fill_q != 7'h00)
      cmd_fill_q <= cmd_fill_q - 7'h01;
  end

  // macro string length and query watch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      macro_cnt_q   <= '0;
      macro_long_q  <= 1'b0;
      macro_query_q <= 1'b0;
    end
    else if (macro_end)
    begin
      macro_cnt_q   <= '0;
      macro_long_q  <= 1'b0;
      macro_query_q <= 1'b0;
    end
    else
    begin
      if (macro_char && macro_cnt_q == 7'(err_report_pkg::MACRO_MAX))
        macro_long_q <= 1'b1;
      else if (macro_char)
        macro_cnt_q <= macro_cnt_q + 7'h01;
      if (macro_trig_query)
        macro_query_q <= 1'b1;
    end
  end

  // history shift and last error; a clear with a new code keeps only the new code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist_q <= '0;
      last_q <= err_report_pkg::E_NONE;
    end
    else if (code_d != err_report_pkg::E_NONE)
    begin
      if (hist_clr)
        hist_q <= {16'h0, code_d};
      else
        hist_q <= {hist_q[15:0], code_d};
      last_q <= code_d;
    end
    else if (hist_clr)
      hist_q <= '0;
  end

  // reject pulse and uncalibrated flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reject_q <= 1'b0;
      nocal_q  <= 1'b0;
    end
    else
    begin
      reject_q <= reject_d;
      if (cal_fail)
        nocal_q <= 1'b1;
      else if (cal_success)
        nocal_q <= 1'b0;
    end
  end

  // front display timer, restarts on each new error while CTRL_MANUAL is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disp_q     <= DISP_IDLE;
      disp_cnt_q <= '0;
      left_q     <= '0;
      right_q    <= '0;
    end
    else if (code_d != err_report_pkg::E_NONE &&
             ctrl_q[err_report_pkg::CTRL_MANUAL])
    begin
      disp_q     <= DISP_SHOW;
      disp_cnt_q <= 32'(DISPLAY_CYCLES - 1);
      left_q     <= err_report_pkg::MARKER_TEXT;
      right_q    <= {err_report_pkg::DIGIT_ZERO, code_d};
    end
    else
    begin
      case (disp_q)
        DISP_IDLE: ;
        DISP_SHOW:
        begin
          if (disp_cnt_q == 32'h0)
          begin
            disp_q  <= DISP_IDLE;
            left_q  <= '0;
            right_q <= '0;
          end
          else
            disp_cnt_q <= disp_cnt_q - 32'h1;
        end
        default: disp_q <= DISP_IDLE;
      endcase
    end
  end

  // outputs straight from flops
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign request_rejected   = reject_q;
  assign uncalibrated_state = nocal_q;
  assign display_active     = disp_q == DISP_SHOW;
  assign display_left       = left_q;
  assign display_right      = right_q;
  assign last_error         = last_q;

endmodule

// >>> bench/apb_host_model.sv
// host side of the register bus: one apb transfer at a time
// assumes the slave raises pready and that pclk is free-running
`timescale 1ns/1ps
module apb_host_model
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // setup, access until pready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err, output bit hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    hung = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// >>> bench/error_code_reporter_monitor.sv
// port checker for the error code reporter
// assumes one pclk domain, presetn async active low
`timescale 1ns/1ps
module error_code_reporter_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        key_unknown,
  input wire logic        esc_brief,
  input wire logic        cmd_char_in,
  input wire logic        setpoint_invalid,
  input wire logic        limit_invalid,
  input wire logic        macro_end,
  input wire logic        rx_char_done,
  input wire logic        parity_fault,
  input wire logic        stop_bit_fault,
  input wire logic        cal_fail,
  input wire logic        output_on_req,
  input wire logic        capture_on_req,
  input wire logic        seq_start_req,
  input wire logic        analog_change_req,
  input wire logic        request_rejected,
  input wire logic        uncalibrated_state,
  input wire logic        display_active,
  input wire logic [23:0] display_left,
  input wire logic [11:0] display_right,
  input wire logic [7:0]  last_error
);
  // faults whose lower codes would win over a serial code
  wire lower = key_unknown | esc_brief | cmd_char_in | setpoint_invalid
             | limit_invalid | macro_end;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  marker_text_a: assert property (
    display_active |-> display_left == err_report_pkg::MARKER_TEXT)
    else $error("left field wrong while showing");
  code_digits_a: assert property (
    display_active |-> display_right == {4'h0, last_error})
    else $error("right field wrong while showing");
  blank_idle_a: assert property (
    !display_active |-> display_left == 24'h0 && display_right == 12'h0)
    else $error("display fields not blank");
  key_code_a: assert property (key_unknown |=> last_error == 8'h05)
    else $error("unknown key not recorded");
  serial_both_a: assert property (
    rx_char_done && parity_fault && stop_bit_fault && !lower
    |=> last_error == 8'h53)
    else $error("double serial fault not recorded");
  setpoint_code_a: assert property (
    setpoint_invalid && !key_unknown && !esc_brief && !cmd_char_in
    |=> last_error == 8'h21)
    else $error("setpoint fault not recorded");
  cal_uncalibrated_state_a: assert property (cal_fail |=> uncalibrated_state)
    else $error("calibration failure left unit calibrated");
  reject_cause_a: assert property (
    request_rejected |-> $past(output_on_req || capture_on_req
                               || seq_start_req || analog_change_req))
    else $error("rejection without a request");

  cover property (request_rejected);
  cover property (pslverr);
  cover property (display_active ##1 !display_active);
  cover property (uncalibrated_state ##1 !uncalibrated_state);
endmodule

bind error_code_reporter error_code_reporter_monitor
  error_code_reporter_monitor_i (.*);

// >>> bench/error_code_reporter_tb.sv
// self-checking bench for the error code reporter
// assumes the host model drives apb and the monitor is bound
`timescale 1ns/1ps
module error_code_reporter_tb;
  localparam int DISP_N = 20;
  logic        pclk;
  logic        presetn;
  logic [35:0] pv;
  logic [3:0]  data_bit_count;
  logic [15:0] table_voltage;
  logic [15:0] table_current;
  logic [1:0]  trigger_input_level;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        request_rejected, uncalibrated_state, display_active, rerr;
  logic [23:0] display_left;
  logic [11:0] display_right;
  logic [7:0]  last_error, last_exp;
  logic [7:0]  hist[$];
  int          fail_count;
  int          samples_checked;
  wire key_unknown, esc_brief, cmd_char_in, cmd_char_take, setpoint_invalid;
  wire limit_invalid, macro_char, macro_trig_query, macro_end, rx_char_done;
  wire parity_fault, stop_bit_fault, serial_cfg_apply, parity_enable;
  wire two_stop_bits, addressed_talk, listener_present, talker_active;
  wire listener_active, cal_param_invalid, calibration_command, cal_step;
  wire cal_step_current, constant_voltage_regulation, cal_limit_set;
  wire constant_current_regulation, cal_meas_bad, cal_fail, cal_success;
  wire mem_check_fail, seq_running, seq_step, output_on_req, capture_on_req;
  wire seq_start_req, analog_change_req;
  // fault strobes and levels, bit 0 first
  logic [35:0] tm[14] = '{36'h1, 36'h10, 36'h20, 36'h600, 36'ha00,
    36'he00, 36'h1000, 36'h80000, 36'h200000, 36'ha00000, 36'he00000,
    36'h6000000, 36'h20000000, 36'h8000000};
  logic [7:0]  tc[14] = '{8'h05, 8'h21, 8'h22, 8'h51, 8'h52, 8'h53, 8'h54,
    8'h61, 8'h63, 8'h00, 8'h63, 8'h64, 8'h69, 8'h66};

  // one vector drives every single-bit fault input
  assign {analog_change_req, seq_start_req, capture_on_req, output_on_req,
          seq_step, seq_running, mem_check_fail, cal_success, cal_fail,
          cal_meas_bad, cal_limit_set, constant_current_regulation,
          constant_voltage_regulation, cal_step_current, cal_step,
          calibration_command, cal_param_invalid, listener_active,
          talker_active, listener_present, addressed_talk, two_stop_bits,
          parity_enable, serial_cfg_apply, stop_bit_fault, parity_fault,
          rx_char_done, macro_end, macro_trig_query, macro_char,
          limit_invalid, setpoint_invalid, cmd_char_take, cmd_char_in,
          esc_brief, key_unknown} = pv;

  error_code_reporter #(.DISPLAY_CYCLES(DISP_N)) error_code_reporter_i (.*);
  apb_host_model apb_host_model_i (.*);

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // register access; a hung bus ends the run
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    bit hung;
    apb_host_model_i.xfer(w, a, d, rdv, rerr, hung);
    if (hung)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  // history model: newest in the low byte, empty entries read 00
  function automatic logic [31:0] hword();
    logic [31:0] w;
    w = 32'h0;
    foreach (hist[i]) w[8*i +: 8] = hist[i];
    return w;
  endfunction

  task automatic rec(input logic [7:0] c);
    if (c != 8'h00)
    begin
      hist.push_front(c);
      if (hist.size() > 3) void'(hist.pop_back());
      last_exp = c;
    end
  endtask

  // one-cycle strobe on the fault vector
  task automatic pulse(input logic [35:0] m);
    @(posedge pclk);
    pv <= m;
    @(posedge pclk);
    pv <= 36'h0;
    #1;
  endtask

  task automatic fault(input logic [35:0] m, input logic [7:0] c);
    pulse(m);
    rec(c);
    chk(last_error, last_exp);
    rdc(err_report_pkg::ADDR_HISTORY, hword());
  endtask

  // main sequence
  initial
  begin
    int idx;
    logic [2:0] md;
    pv = 36'h0;
    data_bit_count = 4'h8;
    table_voltage = 16'h0;
    table_current = 16'h0;
    trigger_input_level = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    last_exp = 8'h00;
    presetn = 1'b0;
    void'($urandom(32'h83971c36));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(err_report_pkg::ADDR_CTRL, 32'h1);
    rdc(err_report_pkg::ADDR_VLIMIT, 32'hffff_0000);
    rdc(err_report_pkg::ADDR_LAST_ERR, 32'h0);
    rdc(err_report_pkg::ADDR_HISTORY, 32'h0);
    rdc(8'h1c, 32'h0);
    chk(rerr, 1'b1);
    data_bit_count <= 4'($urandom_range(6));
    for (int i = 0; i < 14; i++)
    begin
      fault(tm[i], tc[i]);
      if (tc[i] != 8'h00) chk(display_active, 1'b1);
    end
    chk(uncalibrated_state, 1'b1);
    pulse(36'h1);
    rec(8'h05);
    repeat (DISP_N - 1) @(posedge pclk);
    #1;
    chk(display_active, 1'b1);
    @(posedge pclk);
    #1;
    chk(display_active, 1'b0);
    pulse(36'h10000000);
    chk(uncalibrated_state, 1'b0);
    repeat (80) pulse(36'h40);
    fault(36'h100, 8'h00);
    repeat (81) pulse(36'h40);
    fault(36'h100, 8'h29);
    fault(36'h180, 8'h29);
    repeat (64) pulse(36'h4);
    chk(last_error, last_exp);
    fault(36'h4, 8'h12);
    rdc(err_report_pkg::ADDR_STATUS, 32'h8002);
    fault(36'h2, 8'h00);
    bus(1'b1, err_report_pkg::ADDR_CTRL, 32'hd);
    fault(36'h2, 8'h05);
    fault(36'h60000, 8'h56);
    fault(36'h8000, 8'h55);
    repeat (25) @(posedge pclk);
    bus(1'b1, err_report_pkg::ADDR_CTRL, 32'h2);
    fault(36'h100000, 8'h62);
    chk(display_active, 1'b0);
    fault(36'h60000, 8'h00);
    // each trigger conflict, first unblocked then blocked
    for (int k = 0; k < 4; k++)
    begin
      idx = $urandom_range(1);
      md = (k == 0) ? err_report_pkg::TM_OUT : (k == 1) ?
           err_report_pkg::TM_MIN : (k == 2) ? err_report_pkg::TM_SEQ :
           ($urandom_range(1) ? err_report_pkg::TM_AIU : err_report_pkg::TM_AII);
      bus(1'b1, err_report_pkg::ADDR_TRIG_MODE, 32'(md) << (3 * idx));
      for (int s = 0; s < 2; s++)
      begin
        @(posedge pclk);
        trigger_input_level <= 2'(s << idx);
        repeat (3) @(posedge pclk);
        pulse(36'h1 << (32 + k));
        chk(request_rejected, 32'(s));
        rec((s == 1) ? 8'(8'h73 + k) : 8'h00);
        chk(last_error, last_exp);
      end
      @(posedge pclk);
      trigger_input_level <= 2'h0;
    end
    bus(1'b1, err_report_pkg::ADDR_VLIMIT, {16'd100, 16'd10});
    table_voltage <= 16'(10 + $urandom_range(90));
    fault(36'hc0000000, 8'h00);
    table_voltage <= 16'd9;
    fault(36'hc0000000, 8'h71);
    bus(1'b1, err_report_pkg::ADDR_HISTORY, $urandom());
    hist.delete();
    rdc(err_report_pkg::ADDR_HISTORY, 32'h0);
    finish_test();
  end
endmodule
